/* File: include/area_wait_cfg.svh */
/*
 * Indices, fields, reset values and codes of the area wait block.
 * Assumes inclusion by bare name.
 */
`ifndef AREA_WAIT_CFG_SVH
`define AREA_WAIT_CFG_SVH

// ==========================================================
// Register word indices
`define AW_OFS_WAIT_CTRL    6'h00
`define AW_OFS_BUS_CFG      6'h01
`define AW_OFS_STATUS       6'h02

// ==========================================================
// Wait control fields
`define AW_A6_MSB           15
`define AW_A6_LSB           13
`define AW_A5_MSB           12
`define AW_A5_LSB           10
`define AW_A4_MSB           9
`define AW_A4_LSB           7
`define AW_A3_MSB           6
`define AW_A3_LSB           5
`define AW_A2_MSB           4
`define AW_A2_LSB           3
`define AW_A0_MSB           2
`define AW_A0_LSB           0

// ==========================================================
// Reset values
`define AW_WAIT_CTRL_RST    16'hffff
`define AW_MEMTYPE_RST      3'h0

// ==========================================================
// Area 2/3 memory type codes
`define AW_MT_A3_SDRAM      3'h2
`define AW_MT_A23_SDRAM     3'h3

// ==========================================================
// Bus responses
`define AW_RESP_OKAY        2'h0
`define AW_RESP_SLVERR      2'h2

`endif

/* File: include/area_wait_pkg.sv */
/*
 * Types of the area wait block.
 * Assumes the constants header on the include path.
 */
`include "area_wait_cfg.svh"

package area_wait_pkg;

    typedef enum logic [3:0] {
        SEQ_IDLE   = 4'h1,
        SEQ_COUNT  = 4'h2,
        SEQ_EXTEND = 4'h4,
        SEQ_DONE   = 4'h8
    } seq_state_t;

    typedef struct packed {
        // Registers
        logic [15:0] wait_ctrl;
        logic        wait_sel;
        logic [2:0]  memtype;
        // Bus slave
        logic        awready;
        logic        wready;
        logic        aw_held;
        logic        w_held;
        logic [5:0]  aw_idx;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        // Wait pin and bus clock
        logic [2:0]  sync;
        logic        wait_lvl;
        logic        wait_smp;
        logic        bclk;
        // Sequencer
        seq_state_t  seq;
        logic [3:0]  cnt;
        logic [2:0]  area;
        logic        wait_en;
        logic        acc_ready;
        logic        acc_done;
        logic        acc_error;
    } state_t;

endpackage

/* File: logic/area_wait_state_config.sv */
/*
 * Area wait-state settings, access sequencer, AXI4-Lite slave.
 * Assumes a 40 MHz aclk, bus clock out at half rate
 * and an asynchronous active-low wait pin.
 */
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "area_wait_cfg.svh"

module area_wait_state_config (
    // Clock and power-on reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Manual reset and standby
    input  wire logic        manual_reset,
    input  wire logic        standby,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Access requests
    input  wire logic        acc_req,
    input  wire logic [2:0]  acc_area,
    input  wire logic        acc_burst,
    output logic             acc_ready,
    output logic             acc_done,
    output logic             acc_error,
    // Memory side
    input  wire logic        ext_wait_n,
    output logic             bus_clock_out,
    // Decoded settings
    output logic [1:0]       area2_cas_latency,
    output logic [1:0]       area3_cas_latency
);

    area_wait_pkg::state_t st_r;
    area_wait_pkg::state_t st_nxt;

    // ==========================================================
    // Per-area decode: index 0..5 = areas 0,2,3,4,5,6
    logic [2:0] code    [6];
    logic [3:0] first_w [6];
    logic       pin_en  [6];
    logic [3:0] burst_s [6];

    assign code[0] = st_r.wait_ctrl[`AW_A0_MSB:`AW_A0_LSB];
    assign code[1] = {1'b0, st_r.wait_ctrl[`AW_A2_MSB:`AW_A2_LSB]};
    assign code[2] = {1'b0, st_r.wait_ctrl[`AW_A3_MSB:`AW_A3_LSB]};
    assign code[3] = st_r.wait_ctrl[`AW_A4_MSB:`AW_A4_LSB];
    assign code[4] = st_r.wait_ctrl[`AW_A5_MSB:`AW_A5_LSB];
    assign code[5] = st_r.wait_ctrl[`AW_A6_MSB:`AW_A6_LSB];

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_dec
            wait_code_decode u_dec (
                .code         (code[gi]),
                .first_waits  (first_w[gi]),
                .wait_pin_en  (pin_en[gi]),
                .burst_states (burst_s[gi])
            );
        end
    endgenerate

    // CAS latency: 00 and 01 both give 1
    function automatic logic [1:0] cas_of(input logic [1:0] f);
        cas_of = (f == 2'h0) ? 2'h1 : f;
    endfunction

    logic a2_sdram;
    logic a3_sdram;
    assign a3_sdram = (st_r.memtype == `AW_MT_A3_SDRAM) ||
                      (st_r.memtype == `AW_MT_A23_SDRAM);
    assign a2_sdram = (st_r.memtype == `AW_MT_A23_SDRAM);

    // ==========================================================
    // Next state
    always_comb begin
        logic        wr_go;
        logic        rd_hit;
        logic        wr_hit;
        logic [5:0]  ridx;
        logic [31:0] rval;
        logic        rise_en;
        logic        fall_en;
        logic [2:0]  sel;
        logic        valid_area;
        logic        sdram;
        logic [3:0]  load;
        logic        load_en;
        wr_go      = 1'b0;
        rd_hit     = 1'b0;
        wr_hit     = 1'b0;
        ridx       = 6'h0;
        rval       = 32'h0;
        rise_en    = 1'b0;
        fall_en    = 1'b0;
        sel        = 3'h0;
        valid_area = 1'b0;
        sdram      = 1'b0;
        load       = 4'h0;
        load_en    = 1'b0;
        st_nxt     = st_r;

        // Write: address and data in either order
        if (s_axi_awvalid && st_r.awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_idx  = s_axi_awaddr[7:2];
            st_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && st_r.wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
            st_nxt.wready = 1'b0;
        end
        wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
        if (wr_go) begin
            wr_hit = 1'b1;
            case (st_r.aw_idx)
                `AW_OFS_WAIT_CTRL: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.wait_ctrl[7:0] = st_r.w_data[7:0];
                    end
                    if (st_r.w_strb[1]) begin
                        st_nxt.wait_ctrl[15:8] = st_r.w_data[15:8];
                    end
                end
                `AW_OFS_BUS_CFG: begin
                    if (st_r.w_strb[0]) begin
                        st_nxt.wait_sel = st_r.w_data[0];
                        st_nxt.memtype  = st_r.w_data[3:1];
                    end
                end
                `AW_OFS_STATUS: begin
                end
                default: begin
                    wr_hit = 1'b0;
                end
            endcase
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = wr_hit ? `AW_RESP_OKAY : `AW_RESP_SLVERR;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid  = 1'b0;
            st_nxt.awready = 1'b1;
            st_nxt.wready  = 1'b1;
        end

        // Read channel
        if (s_axi_arvalid && st_r.arready) begin
            ridx   = s_axi_araddr[7:2];
            rd_hit = 1'b1;
            case (ridx)
                `AW_OFS_WAIT_CTRL: rval = {16'h0, st_r.wait_ctrl};
                `AW_OFS_BUS_CFG:   rval = {28'h0, st_r.memtype, st_r.wait_sel};
                `AW_OFS_STATUS:    rval = {22'h0, st_r.wait_smp,
                                           st_r.seq == area_wait_pkg::SEQ_EXTEND,
                                           st_r.cnt, st_r.area, !st_r.acc_ready};
                default: begin
                    rd_hit = 1'b0;
                end
            endcase
            st_nxt.rdata   = rval;
            st_nxt.rresp   = rd_hit ? `AW_RESP_OKAY : `AW_RESP_SLVERR;
            st_nxt.rvalid  = 1'b1;
            st_nxt.arready = 1'b0;
        end
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid  = 1'b0;
            st_nxt.arready = 1'b1;
        end

        // Half-rate bus clock; edges as enables
        rise_en     = !st_r.bclk;
        fall_en     = st_r.bclk;
        st_nxt.bclk = !st_r.bclk;

        // Wait pin: three stages, last two must agree
        st_nxt.sync = {st_r.sync[1:0], ext_wait_n};
        if (st_r.sync[1] == st_r.sync[2]) begin
            st_nxt.wait_lvl = !st_r.sync[2];
        end
        if (st_r.wait_sel ? fall_en : rise_en) begin
            st_nxt.wait_smp = st_r.wait_lvl;
        end

        // Sequencer
        st_nxt.acc_done  = 1'b0;
        st_nxt.acc_error = 1'b0;
        case (st_r.seq)
            area_wait_pkg::SEQ_IDLE: begin
                if (acc_req && st_r.acc_ready) begin
                    valid_area = 1'b1;
                    case (acc_area)
                        3'h0: sel = 3'h0;
                        3'h2: sel = 3'h1;
                        3'h3: sel = 3'h2;
                        3'h4: sel = 3'h3;
                        3'h5: sel = 3'h4;
                        3'h6: sel = 3'h5;
                        default: valid_area = 1'b0;
                    endcase
                    sdram = (acc_area == 3'h2 && a2_sdram) ||
                            (acc_area == 3'h3 && a3_sdram);
                    if (!valid_area) begin
                        st_nxt.seq       = area_wait_pkg::SEQ_DONE;
                        st_nxt.acc_done  = 1'b1;
                        st_nxt.acc_error = 1'b1;
                    end else begin
                        load_en = 1'b1;
                        if (sdram) begin
                            load = (acc_area == 3'h2) ?
                                {2'h0, cas_of(code[1][1:0])} :
                                {2'h0, cas_of(code[2][1:0])};
                        end else if (acc_burst &&
                                     (sel == 3'h0 || sel == 3'h4 || sel == 3'h5)) begin
                            load = burst_s[sel] - 4'h1;
                        end else begin
                            load = first_w[sel];
                        end
                        st_nxt.seq     = area_wait_pkg::SEQ_COUNT;
                        st_nxt.cnt     = load;
                        st_nxt.area    = acc_area;
                        // Burst beats in areas 0, 5 and 6 always honour the pin
                        st_nxt.wait_en = !sdram &&
                                         (pin_en[sel] || (acc_burst &&
                                          (sel == 3'h0 || sel == 3'h4 ||
                                           sel == 3'h5)));
                    end
                    st_nxt.acc_ready = 1'b0;
                end
            end
            area_wait_pkg::SEQ_COUNT: begin
                if (rise_en) begin
                    if (st_r.cnt != 4'h0) begin
                        st_nxt.cnt = st_r.cnt - 4'h1;
                    end else if (st_r.wait_en && st_r.wait_smp) begin
                        st_nxt.seq = area_wait_pkg::SEQ_EXTEND;
                    end else begin
                        st_nxt.seq      = area_wait_pkg::SEQ_DONE;
                        st_nxt.acc_done = 1'b1;
                    end
                end
            end
            area_wait_pkg::SEQ_EXTEND: begin
                if (rise_en && !st_r.wait_smp) begin
                    st_nxt.seq      = area_wait_pkg::SEQ_DONE;
                    st_nxt.acc_done = 1'b1;
                end
            end
            area_wait_pkg::SEQ_DONE: begin
                st_nxt.seq       = area_wait_pkg::SEQ_IDLE;
                st_nxt.acc_ready = 1'b1;
            end
            default: begin
                st_nxt.seq       = area_wait_pkg::SEQ_IDLE;
                st_nxt.acc_ready = 1'b1;
            end
        endcase

        // Manual reset, standby: sequencer only
        if (manual_reset || standby) begin
            st_nxt.seq       = area_wait_pkg::SEQ_IDLE;
            st_nxt.cnt       = 4'h0;
            st_nxt.acc_ready = 1'b1;
            st_nxt.acc_done  = 1'b0;
            st_nxt.acc_error = 1'b0;
        end
    end

    // ==========================================================
    // Only power-on reset touches settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r           <= '0;
            st_r.wait_ctrl <= `AW_WAIT_CTRL_RST;
            st_r.memtype   <= `AW_MEMTYPE_RST;
            st_r.awready   <= 1'b1;
            st_r.wready    <= 1'b1;
            st_r.arready   <= 1'b1;
            st_r.sync      <= 3'h7;
            st_r.seq       <= area_wait_pkg::SEQ_IDLE;
            st_r.acc_ready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready     = st_r.awready;
    assign s_axi_wready      = st_r.wready;
    assign s_axi_bvalid      = st_r.bvalid;
    assign s_axi_bresp       = st_r.bresp;
    assign s_axi_arready     = st_r.arready;
    assign s_axi_rvalid      = st_r.rvalid;
    assign s_axi_rresp       = st_r.rresp;
    assign s_axi_rdata       = st_r.rdata;
    assign acc_ready         = st_r.acc_ready;
    assign acc_done          = st_r.acc_done;
    assign acc_error         = st_r.acc_error;
    assign bus_clock_out     = st_r.bclk;

    logic [1:0] cas2_r;
    logic [1:0] cas3_r;
    logic [1:0] cas2_nxt;
    logic [1:0] cas3_nxt;
    assign cas2_nxt = cas_of(st_r.wait_ctrl[`AW_A2_MSB:`AW_A2_LSB]);
    assign cas3_nxt = cas_of(st_r.wait_ctrl[`AW_A3_MSB:`AW_A3_LSB]);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cas2_r <= 2'h3;
            cas3_r <= 2'h3;
        end else begin
            cas2_r <= cas2_nxt;
            cas3_r <= cas3_nxt;
        end
    end
    assign area2_cas_latency = cas2_r;
    assign area3_cas_latency = cas3_r;

endmodule

`default_nettype wire

/* File: logic/wait_code_decode.sv */
/*
 * Decodes one area wait code: first waits, pin enable, pitch.
 * Assumes two-bit codes arrive zero-extended.
 */
`timescale 1ns/1ps
`default_nettype none

module wait_code_decode (
    // Code
    input  wire logic [2:0] code,
    // Decoded values
    output logic      [3:0] first_waits,
    output logic            wait_pin_en,
    output logic      [3:0] burst_states
);

    always_comb begin
        case (code)
            3'h0: begin
                first_waits  = 4'h0;
                burst_states = 4'h2;
            end
            3'h1: begin
                first_waits  = 4'h1;
                burst_states = 4'h2;
            end
            3'h2: begin
                first_waits  = 4'h2;
                burst_states = 4'h3;
            end
            3'h3: begin
                first_waits  = 4'h3;
                burst_states = 4'h4;
            end
            3'h4: begin
                first_waits  = 4'h4;
                burst_states = 4'h4;
            end
            3'h5: begin
                first_waits  = 4'h6;
                burst_states = 4'h6;
            end
            3'h6: begin
                first_waits  = 4'h8;
                burst_states = 4'h8;
            end
            default: begin
                first_waits  = 4'ha;
                burst_states = 4'ha;
            end
        endcase
        // Zero code ignores the pin
        wait_pin_en = (code != 3'h0);
    end

endmodule

`default_nettype wire

/* File: tb/area_wait_asserts.sv */
/*
 * Checker of the area wait block's ports.
 * Assumes a bind onto the top module, one clock.
 */
`timescale 1ns/1ps
`default_nettype none

module area_wait_asserts (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Access and memory side
    input wire logic        acc_req,
    input wire logic        acc_ready,
    input wire logic        acc_done,
    input wire logic        acc_error,
    input wire logic        bus_clock_out,
    input wire logic [1:0]  area2_cas_latency,
    input wire logic [1:0]  area3_cas_latency
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // Sequences
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_bresp;
        ##2 s_axi_bvalid;
    endsequence

    // ==========================================================
    // Properties
    property p_rst;
        $rose(aresetn) |-> acc_ready && {area2_cas_latency, area3_cas_latency} == 4'hf;
    endproperty
    property p_wr_ans;
        s_wr_take |-> s_bresp;
    endproperty
    property p_rd_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_req_busy;
        acc_req && acc_ready |=> !acc_ready;
    endproperty
    property p_done_bound;
        acc_req && acc_ready |-> ##[2:300] acc_done;
    endproperty
    property p_done_pulse;
        acc_done |=> acc_ready && !acc_done;
    endproperty
    property p_err;
        acc_error |-> acc_done;
    endproperty
    property p_bclk;
        $past(aresetn) |-> bus_clock_out != $past(bus_clock_out);
    endproperty
    property p_cas;
        area2_cas_latency != 2'h0 && area3_cas_latency != 2'h0;
    endproperty

    a_rst: assert property (p_rst) else $error("reset outputs wrong");
    a_wr_ans: assert property (p_wr_ans) else $error("write response late");
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_req_busy: assert property (p_req_busy) else $error("request not taken");
    a_done_bound: assert property (p_done_bound) else $error("access never ends");
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
    a_err: assert property (p_err) else $error("error without done");
    a_bclk: assert property (p_bclk) else $error("bus clock stuck");
    a_cas: assert property (p_cas) else $error("latency zero");
endmodule

bind area_wait_state_config area_wait_asserts area_wait_asserts_i (.*);

`default_nettype wire

/* File: tb/ext_mem_model.sv */
/*
 * Slow memory: wait pin low for hold clocks per access.
 * Assumes a pulled-up pin.
 */
`timescale 1ns/1ps
`default_nettype none

module ext_mem_model (
    // Clock and access state
    input wire logic       aclk,
    input wire logic       acc_ready,
    input wire logic [7:0] hold,
    // Wait pin
    output logic           ext_wait_n
);
    logic       idle_q = 1'b1;
    logic [7:0] cnt_r = 8'h00;

    always @(posedge aclk) begin
        idle_q <= acc_ready;
        if (idle_q && !acc_ready)
            cnt_r <= hold;
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
    end
    // Released pin at pull-up level
    assign ext_wait_n = (cnt_r == 8'h00);
endmodule

`default_nettype wire

/* File: tb/tb_top.sv */
/*
 * Bench of the area wait block.
 * Assumes design, package and model compiled.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        manual_reset = 1'b0;
    logic        standby = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        acc_req = 1'b0;
    logic [2:0]  acc_area = 3'h0;
    logic        acc_burst = 1'b0;
    logic        acc_ready, acc_done, acc_error, ext_wait_n, bus_clock_out;
    logic [1:0]  area2_cas_latency, area3_cas_latency;
    logic [7:0]  hold = 8'h00;
    logic [31:0] seed = 32'h00010351;
    int          err_total = 0;
    int          checks_done = 0;

    area_wait_state_config area_wait_state_config_i (.*);
    ext_mem_model ext_mem_model_i (.*);

    always #12.5 aclk = ~aclk;

    // ==========================================================
    // Expectations
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int f_w(input logic [2:0] c);
        return (c < 3'h5) ? c : 2 * c - 4;
    endfunction
    function automatic logic [1:0] f_cas(input logic [1:0] c);
        return (c == 2'h0) ? 2'h1 : c;
    endfunction
    function automatic int f_n(input logic [2:0] a, input logic b, input logic [15:0] w,
                               input logic [2:0] mt);
        logic [2:0] c;
        c = (a == 3'h0) ? w[2:0] : (a == 3'h2) ? {1'b0, w[4:3]} : (a == 3'h3) ? {1'b0, w[6:5]} :
            (a == 3'h4) ? w[9:7] : (a == 3'h5) ? w[12:10] : w[15:13];
        if ((a == 3'h3 && mt[1]) || (a == 3'h2 && mt == 3'h3))
            return f_cas(c[1:0]);
        if (b && (a == 3'h0 || a > 3'h4))
            return ((c < 3'h2) ? 2 : (c < 3'h4) ? c + 1 : f_w(c)) - 1;
        return f_w(c);
    endfunction

    // ==========================================================
    // Compare and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("unexpected at %0t: cycles %h range %h %h", $time, got, lo, hi);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
    endtask
    task automatic acc(input logic [2:0] a, input logic b, output int n);
        acc_area <= a;
        acc_burst <= b;
        acc_req <= 1'b1;
        n = 0;
        for (int i = 0; i < 400; i++) begin
            @(posedge aclk);
            if (acc_req && acc_ready) acc_req <= 1'b0;
            else if (!acc_req) n++;
            if (acc_done) break;
        end
    endtask
    task automatic test_done;
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #(25 * 30000);
        err_total++;
        test_done;
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] wc;
        logic [2:0]  a;
        logic [2:0]  ar [6];
        int          n;
        ar = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(8'h00, d, r);
        chk(d, 32'h0000ffff);
        chk({28'h0, area3_cas_latency, area2_cas_latency}, 32'hf);
        for (int k = 0; k < 14; k++) begin
            a = k[2:0];
            d = xs();
            wc = (k < 8) ? {a, a, a, a[1:0], a[1:0], a} : d[15:0];
            axi_wr(8'h00, {d[31:16], wc}, r);
            chk({30'h0, r}, 32'h0);
            axi_rd(8'h00, d, r);
            chk(d, {16'h0, wc});
            chk({area3_cas_latency, area2_cas_latency}, {f_cas(wc[6:5]), f_cas(wc[4:3])});
            for (int j = 0; j < 12; j++) begin
                acc(ar[j % 6], j / 6, n);
                chk_rng(n - 2 * f_n(ar[j % 6], j / 6, wc, 3'h0), 1, 5);
            end
        end
        // Area 3, then areas 2 and 3, as SDRAM
        for (int m = 2; m < 4; m++) begin
            axi_wr(8'h04, m * 2, r);
            for (int j = 1; j < 3; j++) begin
                acc(ar[j], 1'b0, n);
                chk_rng(n - 2 * f_n(ar[j], 1'b0, wc, m), 1, 5);
            end
        end
        // Slow memory
        hold <= 8'd40;
        for (int s = 0; s < 2; s++) begin
            axi_wr(8'h04, s, r);
            axi_wr(8'h00, 32'he000, r);
            acc(3'h6, 1'b0, n);
            chk_rng(n, 40, 70);
            acc(3'h0, 1'b0, n);
            chk_rng(n, 1, 5);
            acc(3'h4, 1'b0, n);
            chk_rng(n, 1, 5);
            acc(3'h5, 1'b0, n);
            chk_rng(n, 1, 5);
            acc(3'h6, 1'b1, n);
            chk_rng(n, 40, 70);
        end
        hold <= 8'd0;
        // Refused and read-only
        axi_rd(8'h3c, d, r);
        chk({r, d[29:0]}, 32'h80000000);
        axi_wr(8'h3c, 32'h0, r);
        chk({30'h0, r}, 32'h2);
        axi_wr(8'h08, 32'hffff, r);
        chk({30'h0, r}, 32'h0);
        axi_rd(8'h00, d, r);
        chk(d, 32'he000);
        // Manual reset, standby, power-on reset
        manual_reset <= 1'b1;
        repeat (3) @(posedge aclk);
        manual_reset <= 1'b0;
        standby <= 1'b1;
        repeat (3) @(posedge aclk);
        standby <= 1'b0;
        @(posedge aclk);
        axi_rd(8'h00, d, r);
        chk(d, 32'he000);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(8'h00, d, r);
        chk(d, 32'hffff);
        axi_rd(8'h04, d, r);
        chk(d, 32'h0);
        test_done;
    end
endmodule

`default_nettype wire
